/* File: rtl/ppdm_data_mux.v */
// parallel port data pin multiplexer, top level
`timescale 1ns/1ps
`include "ppdm_consts.vh"

module ppdm_data_mux (
   input wire clk_i,
   input wire resetn_i,
   input wire boot_select_strap_i,
   input wire hold_req_i,
   input wire test_resetn_i,
   input wire emulation_pin_zero_i,
   input wire emulation_off_pin_i,
   input wire [31:0] pad_in_i,
   input wire [15:0] host_port_addr_i,
   input wire host_cycle_i,
   input wire host_write_i,
   input wire [3:0] reg_addr_i,
   input wire [31:0] reg_wdata_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   output reg [31:0] pad_out_o,
   output reg [31:0] pad_oe_o,
   output reg [31:0] keep_val_o,
   output reg [31:0] keep_en_o,
   output reg [15:0] host_port_addr_o,
   output reg host_word_done_o,
   output reg [31:0] reg_rdata_o
);
   //----------------------------------------------------------------
   // declarations
   //----------------------------------------------------------------
   wire mode;
   wire locked;
   wire float_all;
   wire off_mode;
   wire gpio_sel;
   wire [15:0] keep_hi;
   wire [15:0] keep_lo;
   wire [15:0] keep_en_hi;
   wire [15:0] keep_en_lo;
   reg holder_en_reg;
   reg [15:0] gpio_out_reg;
   reg [15:0] gpio_dir_reg;
   reg [15:0] host_tx_reg;
   reg [15:0] host_rx_reg;
   reg [31:0] mem_out_reg;
   reg mem_drive_reg;
   reg host_wr_seen_reg;
   reg host_rd_seen_reg;
   reg [31:0] pad_out_next;
   reg [31:0] pad_oe_next;
   reg [31:0] rdata_next;

   //----------------------------------------------------------------
   // strap capture
   //----------------------------------------------------------------
   // mode stays stable until the next reset, regardless of the strap
   ppdm_strap_latch u_strap (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .boot_select_strap_i(boot_select_strap_i),
      .mode_o(mode),
      .locked_o(locked)
   );

   // off mode: test reset 0, emulation pin zero 1, emulation-off pin 0
   assign off_mode = ~test_resetn_i & emulation_pin_zero_i &
      ~emulation_off_pin_i;
   // before the strap is locked the pins also stay released
   assign float_all = ~resetn_i | ~locked | hold_req_i |
      off_mode;
   assign gpio_sel = (mode == `PPDM_MODE_GPIO_HOST);

   //----------------------------------------------------------------
   // register writes
   //----------------------------------------------------------------
   // all direction state clears at reset, so every function is input
   always @(posedge clk_i) begin
      if (!resetn_i) begin
         holder_en_reg <= 1'b1;
         gpio_out_reg <= `PPDM_HALF_ZERO;
         gpio_dir_reg <= `PPDM_HALF_ZERO;
         host_tx_reg <= `PPDM_HALF_ZERO;
         mem_out_reg <= `PPDM_WORD_ZERO;
         mem_drive_reg <= 1'b0;
      end else if (reg_wr_i) begin
         case (reg_addr_i)
            `PPDM_REG_CTRL: begin
               holder_en_reg <= reg_wdata_i[`PPDM_CTRL_HOLDER_EN_BIT];
            end
            `PPDM_REG_GPIO_OUT: begin
               gpio_out_reg <= reg_wdata_i[15:0];
            end
            `PPDM_REG_GPIO_DIR: begin
               gpio_dir_reg <= reg_wdata_i[15:0];
            end
            `PPDM_REG_HOST_TX: begin
               host_tx_reg <= reg_wdata_i[15:0];
            end
            `PPDM_REG_MEM_OUT: begin
               mem_out_reg <= reg_wdata_i;
               mem_drive_reg <= 1'b1; // memory write cycle drives the bus
            end
            `PPDM_REG_MEM_IN: begin
               mem_drive_reg <= 1'b0; // writing here returns bus to input
            end
            default: begin
            end
         endcase
      end
   end

   //----------------------------------------------------------------
   // host port data transfers
   //----------------------------------------------------------------
   // one 16-bit word per host cycle; write captures, read drives
   always @(posedge clk_i) begin
      if (!resetn_i) begin
         host_rx_reg <= `PPDM_HALF_ZERO;
         host_port_addr_o <= `PPDM_HALF_ZERO;
         host_word_done_o <= 1'b0;
         host_wr_seen_reg <= 1'b0;
         host_rd_seen_reg <= 1'b0;
      end else begin
         host_word_done_o <= host_cycle_i & gpio_sel & locked;
         if (host_cycle_i && gpio_sel && locked) begin
            host_port_addr_o <= host_port_addr_i;
            if (host_write_i) begin
               host_rx_reg <= pad_in_i[15:0];
            end
         end
         // set wins over a clear by status read in the same cycle
         if (host_cycle_i && gpio_sel && locked && host_write_i) begin
            host_wr_seen_reg <= 1'b1;
         end else if (reg_rd_i && reg_addr_i == `PPDM_REG_STATUS) begin
            host_wr_seen_reg <= 1'b0;
         end
         if (host_cycle_i && gpio_sel && locked && !host_write_i) begin
            host_rd_seen_reg <= 1'b1;
         end else if (reg_rd_i && reg_addr_i == `PPDM_REG_STATUS) begin
            host_rd_seen_reg <= 1'b0;
         end
      end
   end

   //----------------------------------------------------------------
   // pin function mux
   //----------------------------------------------------------------
   always @* begin
      pad_out_next = `PPDM_WORD_ZERO;
      pad_oe_next = `PPDM_WORD_ZERO;
      if (gpio_sel) begin
         pad_out_next[31:16] = gpio_out_reg;
         pad_oe_next[31:16] = gpio_dir_reg;
         pad_out_next[15:0] = host_tx_reg;
         // host read cycles drive the data, otherwise input
         pad_oe_next[15:0] = {16{host_cycle_i & ~host_write_i}};
      end else begin
         pad_out_next = mem_out_reg;
         pad_oe_next = {32{mem_drive_reg}};
      end
      if (float_all) begin
         pad_oe_next = `PPDM_WORD_ZERO;
      end
   end

   // registered pins; reset forces every enable off
   always @(posedge clk_i) begin
      if (!resetn_i) begin
         pad_out_o <= `PPDM_WORD_ZERO;
         pad_oe_o <= `PPDM_WORD_ZERO;
      end else begin
         pad_out_o <= pad_out_next;
         pad_oe_o <= pad_oe_next;
      end
   end

   //----------------------------------------------------------------
   // bus holders
   //----------------------------------------------------------------
   ppdm_bus_holder u_hold_hi (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .holder_en_i(holder_en_reg),
      .pad_out_i(pad_out_o[31:16]),
      .pad_oe_i(pad_oe_o[31:16]),
      .pad_in_i(pad_in_i[31:16]),
      .keep_val_o(keep_hi),
      .keep_en_o(keep_en_hi)
   );

   ppdm_bus_holder u_hold_lo (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .holder_en_i(holder_en_reg),
      .pad_out_i(pad_out_o[15:0]),
      .pad_oe_i(pad_oe_o[15:0]),
      .pad_in_i(pad_in_i[15:0]),
      .keep_val_o(keep_lo),
      .keep_en_o(keep_en_lo)
   );

   // holder outputs re-registered so top outputs come from flops
   always @(posedge clk_i) begin
      if (!resetn_i) begin
         keep_val_o <= `PPDM_WORD_ZERO;
         keep_en_o <= `PPDM_WORD_ZERO;
      end else begin
         keep_val_o <= {keep_hi, keep_lo};
         keep_en_o <= {keep_en_hi, keep_en_lo};
      end
   end

   //----------------------------------------------------------------
   // register reads
   //----------------------------------------------------------------
   // unmapped indexes read as zero
   always @* begin
      rdata_next = `PPDM_WORD_ZERO;
      case (reg_addr_i)
         `PPDM_REG_CTRL: begin
            rdata_next[`PPDM_CTRL_HOLDER_EN_BIT] = holder_en_reg;
         end
         `PPDM_REG_STATUS: begin
            rdata_next[`PPDM_STAT_MODE_BIT] = mode;
            rdata_next[`PPDM_STAT_HOLD_BIT] = hold_req_i;
            rdata_next[`PPDM_STAT_OFF_BIT] = off_mode;
            rdata_next[`PPDM_STAT_HOST_WR_BIT] = host_wr_seen_reg;
            rdata_next[`PPDM_STAT_HOST_RD_BIT] = host_rd_seen_reg;
         end
         `PPDM_REG_GPIO_OUT: begin
            rdata_next[15:0] = gpio_out_reg;
         end
         `PPDM_REG_GPIO_DIR: begin
            rdata_next[15:0] = gpio_dir_reg;
         end
         `PPDM_REG_GPIO_IN: begin
            rdata_next[15:0] = pad_in_i[31:16];
         end
         `PPDM_REG_HOST_TX: begin
            rdata_next[15:0] = host_tx_reg;
         end
         `PPDM_REG_HOST_RX: begin
            rdata_next[15:0] = host_rx_reg;
         end
         `PPDM_REG_MEM_OUT: begin
            rdata_next = mem_out_reg;
         end
         `PPDM_REG_MEM_IN: begin
            rdata_next = pad_in_i;
         end
         default: begin
            rdata_next = `PPDM_WORD_ZERO;
         end
      endcase
   end

   // data stands only in the cycle after the read strobe
   always @(posedge clk_i) begin
      if (!resetn_i) begin
         reg_rdata_o <= `PPDM_WORD_ZERO;
      end else if (reg_rd_i) begin
         reg_rdata_o <= rdata_next;
      end else begin
         reg_rdata_o <= `PPDM_WORD_ZERO;
      end
   end
endmodule // ppdm_data_mux

/* File: rtl/ppdm_consts.vh */
// constants for the parallel port data pin multiplexer
`ifndef PPDM_CONSTS_VH
`define PPDM_CONSTS_VH

// register indexes on the plain register port
`define PPDM_ADDR_W 4
`define PPDM_REG_CTRL 4'h0
`define PPDM_REG_STATUS 4'h1
`define PPDM_REG_GPIO_OUT 4'h2
`define PPDM_REG_GPIO_DIR 4'h3
`define PPDM_REG_GPIO_IN 4'h4
`define PPDM_REG_HOST_TX 4'h5
`define PPDM_REG_HOST_RX 4'h6
`define PPDM_REG_MEM_OUT 4'h7
`define PPDM_REG_MEM_IN 4'h8

// ext_bus_control_reg fields
`define PPDM_CTRL_HOLDER_EN_BIT 0
`define PPDM_CTRL_RESET 32'h0000_0001

// status fields
`define PPDM_STAT_MODE_BIT 0
`define PPDM_STAT_HOLD_BIT 1
`define PPDM_STAT_OFF_BIT 2
`define PPDM_STAT_HOST_WR_BIT 3
`define PPDM_STAT_HOST_RD_BIT 4

// pin counts and reset values
`define PPDM_HALF_W 16
`define PPDM_PIN_W 32
`define PPDM_HALF_ZERO 16'h0000
`define PPDM_WORD_ZERO 32'h0000_0000

// pin function codes
`define PPDM_MODE_GPIO_HOST 1'b0
`define PPDM_MODE_MEMORY 1'b1

`endif

/* File: rtl/ppdm_bus_holder.v */
// bus holder model for one group of data pins
`timescale 1ns/1ps
module ppdm_bus_holder (
   input wire clk_i,
   input wire resetn_i,
   input wire holder_en_i,
   input wire [15:0] pad_out_i,
   input wire [15:0] pad_oe_i,
   input wire [15:0] pad_in_i,
   output reg [15:0] keep_val_o,
   output reg [15:0] keep_en_o
);
   // per pin: remember last driven level, keep it when nobody drives
   genvar g;
   generate
      for (g = 0; g < 16; g = g + 1) begin : g_pin
         always @(posedge clk_i) begin
            if (!resetn_i) begin
               keep_val_o[g] <= 1'b0;
               keep_en_o[g] <= 1'b0;
            end else begin
               if (pad_oe_i[g]) begin
                  keep_val_o[g] <= pad_out_i[g];
               end else begin
                  keep_val_o[g] <= pad_in_i[g]; // outside driver wins
               end
               keep_en_o[g] <= holder_en_i & ~pad_oe_i[g];
            end
         end
      end
   endgenerate
endmodule // ppdm_bus_holder

/* File: rtl/ppdm_strap_latch.v */
// strap capture at reset release
`timescale 1ns/1ps
module ppdm_strap_latch (
   input wire clk_i,
   input wire resetn_i,
   input wire boot_select_strap_i,
   output reg mode_o,
   output reg locked_o
);
   // strap follows while reset is low, freezes on the first edge after
   // release; a reset flop never samples a port, so capture is clocked
   always @(posedge clk_i) begin
      if (!resetn_i) begin
         locked_o <= 1'b0;
      end else begin
         locked_o <= 1'b1;
      end
   end

   always @(posedge clk_i) begin
      if (!locked_o) begin
         mode_o <= boot_select_strap_i;
      end
   end
endmodule // ppdm_strap_latch

/* File: tb/ppdm_sva.sv */
// assertion checker for the data pin multiplexer
`timescale 1ns/1ps
`include "ppdm_consts.vh"
module ppdm_sva (
   input wire clk_i,
   input wire resetn_i,
   input wire boot_select_strap_i,
   input wire hold_req_i,
   input wire test_resetn_i,
   input wire emulation_pin_zero_i,
   input wire emulation_off_pin_i,
   input wire host_cycle_i,
   input wire host_write_i,
   input wire [3:0] reg_addr_i,
   input wire [31:0] reg_wdata_i,
   input wire reg_wr_i,
   input wire [31:0] pad_oe_o,
   input wire [31:0] keep_en_o,
   input wire host_word_done_o
);
   // ----------------
   // shadow state
   // ----------------
   reg lk_reg;
   reg md_reg;
   reg hen_reg;
   wire off_w;
   wire idle_w;
   wire hrd_w;
   assign off_w = !test_resetn_i && emulation_pin_zero_i &&
      !emulation_off_pin_i;
   assign idle_w = lk_reg && hen_reg && pad_oe_o == 32'h0;
   assign hrd_w = lk_reg && !md_reg && host_cycle_i && !host_write_i;
   // own copy of mode and holder enable, so checks never trust the design
   always @(posedge clk_i) begin
      if (!resetn_i) begin
         lk_reg <= 1'b0;
         md_reg <= 1'b0;
         hen_reg <= 1'b1;
      end else begin
         if (!lk_reg) begin
            lk_reg <= 1'b1;
            md_reg <= boot_select_strap_i;
         end
         if (reg_wr_i && reg_addr_i == `PPDM_REG_CTRL) begin
            hen_reg <= reg_wdata_i[`PPDM_CTRL_HOLDER_EN_BIT];
         end
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   // ----------------
   // properties
   // ----------------
   a_reset_float: assert property (
      disable iff (1'b0) !resetn_i |=> pad_oe_o == 32'h0)
      else $error("pins driven in reset");
   a_hold_float: assert property (
      hold_req_i |=> pad_oe_o == 32'h0) else $error("pins driven in hold");
   a_off_float: assert property (
      off_w |=> pad_oe_o == 32'h0) else $error("pins driven in off mode");
   a_inputs_after: assert property (
      $rose(resetn_i) |-> pad_oe_o == 32'h0)
      else $error("pins out at release");
   a_host_word: assert property (
      lk_reg && !md_reg && host_cycle_i |=> host_word_done_o)
      else $error("host word not done");
   a_mem_quiet: assert property (
      md_reg |=> !host_word_done_o) else $error("host word in memory mode");
   a_done_cause: assert property (
      host_word_done_o |-> $past(host_cycle_i)) else $error("stray word done");
   a_host_drive: assert property (
      hrd_w && !hold_req_i && !off_w |=> pad_oe_o[15:0] == 16'hffff)
      else $error("host read not driven");
   a_holder_gate: assert property (
      !hen_reg [*3] |-> keep_en_o == 32'h0)
      else $error("holder kept when off");
   a_holder_keep: assert property (
      idle_w [*4] |-> keep_en_o == 32'hffff_ffff) else $error("holder idle");
   // main scenarios reached
   c_host_read: cover property (hrd_w);
   c_mem_write: cover property (md_reg && reg_wr_i);
   c_holder_off: cover property (hen_reg ##1 !hen_reg);
endmodule // ppdm_sva

/* File: tb/ppdm_far_end.sv */
// far-side pin model: memories or host sharing the data pins
`timescale 1ns/1ps
module ppdm_far_end (
   input wire clk_i,
   input wire [31:0] pad_out_i,
   input wire [31:0] pad_oe_i,
   input wire [31:0] keep_val_i,
   input wire [31:0] keep_en_i,
   input wire [31:0] drv_en_i,
   input wire [31:0] drv_val_i,
   output wire [31:0] pad_in_o
);
   // ----------------
   // pin resolution
   // ----------------
   reg [31:0] last_reg = 32'h0;
   wire [31:0] flt_w;
   // a pin nobody holds flips, so a stale level can never pass as kept
   assign flt_w = (keep_en_i & keep_val_i) | (~keep_en_i & ~last_reg);
   // far side drives wherever the bench enables it and the design does not drive
   assign pad_in_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ((drv_en_i &
      drv_val_i) | (~drv_en_i & flt_w)));
   // remember the last level for the floating case
   always @(posedge clk_i) begin
      last_reg <= pad_in_o;
   end
endmodule // ppdm_far_end

/* File: tb/ppdm_data_mux_tb.sv */
// self-checking bench for the data pin multiplexer
`timescale 1ns/1ps
`include "ppdm_consts.vh"
module ppdm_data_mux_tb;
   // ----------------
   // signals and parts
   // ----------------
   reg clk_i = 1'b0;
   reg resetn_i, boot_select_strap_i, hold_req_i, test_resetn_i;
   reg emulation_pin_zero_i, emulation_off_pin_i, host_cycle_i, host_write_i;
   reg reg_wr_i, reg_rd_i;
   reg rd_d = 1'b0;
   reg [3:0] reg_addr_i;
   reg [15:0] host_port_addr_i;
   reg [31:0] reg_wdata_i, drv_en, drv_val, seed;
   reg [31:0] expq[$];
   wire [31:0] pad_in_i, pad_out_o, pad_oe_o, keep_val_o, keep_en_o;
   wire [31:0] reg_rdata_o;
   wire [15:0] host_port_addr_o;
   wire host_word_done_o;
   integer errors = 0;
   integer n_compared = 0;
   // 250 MHz
   always #2 clk_i = ~clk_i;
   ppdm_data_mux u_ppdm_data_mux (.clk_i, .resetn_i, .boot_select_strap_i,
      .hold_req_i, .test_resetn_i, .emulation_pin_zero_i,
      .emulation_off_pin_i, .pad_in_i, .host_port_addr_i, .host_cycle_i,
      .host_write_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
      .pad_out_o, .pad_oe_o, .keep_val_o, .keep_en_o, .host_port_addr_o,
      .host_word_done_o, .reg_rdata_o);
   ppdm_far_end u_ppdm_far_end (.clk_i(clk_i), .pad_out_i(pad_out_o),
      .pad_oe_i(pad_oe_o), .keep_val_i(keep_val_o), .keep_en_i(keep_en_o),
      .drv_en_i(drv_en), .drv_val_i(drv_val), .pad_in_o(pad_in_i));
   task check(input [31:0] seen, input [31:0] exp);
      n_compared = n_compared + 1;
      if (seen !== exp) begin
         errors = errors + 1;
         $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   // one register cycle; a read leaves its expectation in the queue
   task bus(input w, input [3:0] a, input [31:0] d);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= w;
      reg_rd_i <= !w;
      if (!w) expq.push_back(d);
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
      reg_rd_i <= 1'b0;
   endtask
   // one host word; on a write the far side drives the low half meanwhile
   task host(input w);
      @(posedge clk_i);
      host_cycle_i <= 1'b1;
      host_write_i <= w;
      host_port_addr_i <= seed[31:16];
      drv_en <= {16'h0, {16{w}}};
      @(posedge clk_i);
      host_cycle_i <= 1'b0;
      drv_en <= 32'h0;
      #1;
   endtask
   task far(input [31:0] en, input [31:0] val);
      @(posedge clk_i);
      drv_en <= en;
      drv_val <= val;
   endtask
   // bounded wait for the pins to turn round, then compare them
   task pins(input [31:0] m, input [31:0] e);
      integer k;
      // data lags the enable when the value register was written last
      for (k = 0; k < 8 && ((pad_oe_o & m) !== m ||
         (pad_out_o & m) !== (e & m)); k = k + 1) @(posedge clk_i);
      #1;
      check(pad_oe_o & m, m);
      check(pad_out_o & m, e & m);
   endtask
   // strap changes right after the lock edge must not count
   task rst(input s);
      @(posedge clk_i);
      resetn_i <= 1'b0;
      boot_select_strap_i <= s;
      repeat (12) @(posedge clk_i);
      check(pad_oe_o, 32'h0);
      resetn_i <= 1'b1;
      @(posedge clk_i);
      boot_select_strap_i <= !s;
      repeat (2) @(posedge clk_i);
   endtask
   function [31:0] xs(input [31:0] x);
      xs = x ^ (x << 13);
      xs = xs ^ (xs >> 17);
      xs = xs ^ (xs << 5);
   endfunction
   task end_sim;
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // read data stand only in the cycle after the strobe
   always @(posedge clk_i) begin
      rd_d <= reg_rd_i;
      if (rd_d) check(reg_rdata_o, expq.pop_front());
   end
   // cut a hang short: about a hundred times the expected run
   initial begin
      #40000;
      errors = errors + 1;
      end_sim;
   end
   // ----------------
   // scenarios
   // ----------------
   initial begin
      {resetn_i, boot_select_strap_i, hold_req_i, test_resetn_i} = 4'h1;
      {emulation_pin_zero_i, emulation_off_pin_i, host_cycle_i} = 3'h0;
      {host_write_i, reg_wr_i, reg_rd_i, reg_addr_i} = 7'h00;
      {host_port_addr_i, reg_wdata_i, drv_en, drv_val} = 112'h0;
      seed = 32'h0000_0056;
      rst(1'b0);
      bus(0, `PPDM_REG_CTRL, `PPDM_CTRL_RESET);
      bus(0, `PPDM_REG_STATUS, 32'h0);
      seed = xs(seed);
      bus(1, `PPDM_REG_HOST_TX, {16'h0, seed[15:0]});
      host(1'b0);
      check({pad_oe_o[15:0], pad_out_o[15:0]},
         {16'hffff, seed[15:0]});
      check({15'h0, host_word_done_o, host_port_addr_o},
         {15'h0, 1'b1, seed[31:16]});
      seed = xs(seed);
      drv_val <= seed;
      host(1'b1);
      bus(0, `PPDM_REG_HOST_RX, {16'h0, seed[15:0]});
      bus(0, `PPDM_REG_STATUS, 32'h18);
      bus(0, `PPDM_REG_STATUS, 32'h0);
      far(32'hffff_0000, seed);
      bus(0, `PPDM_REG_GPIO_IN, {16'h0, seed[31:16]});
      far(32'h0, 32'h0);
      // far side let go: the holders must keep the level it drove last
      repeat (3) @(posedge clk_i);
      #1;
      check({16'h0, keep_val_o[31:16]}, {16'h0, seed[31:16]});
      check(keep_en_o, 32'hffff_ffff);
      bus(1, `PPDM_REG_GPIO_DIR, 32'h0000_ffff);
      bus(1, `PPDM_REG_GPIO_OUT, {16'h0, seed[15:0]});
      pins(32'hffff_0000, {seed[15:0], 16'h0});
      @(posedge clk_i);
      hold_req_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      check(pad_oe_o, 32'h0);
      hold_req_i <= 1'b0;
      test_resetn_i <= 1'b0;
      emulation_pin_zero_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      check(pad_oe_o, 32'h0);
      {test_resetn_i, emulation_pin_zero_i} <= 2'b10;
      bus(1, `PPDM_REG_CTRL, 32'h0);
      bus(0, `PPDM_REG_CTRL, 32'h0);
      bus(1, `PPDM_REG_CTRL, `PPDM_CTRL_RESET);
      rst(1'b1);
      bus(0, `PPDM_REG_STATUS, 32'h1);
      seed = xs(seed);
      far(32'hffff_ffff, seed);
      bus(0, `PPDM_REG_MEM_IN, seed);
      far(32'h0, 32'h0);
      host(1'b0);
      check({31'h0, host_word_done_o}, 32'h0);
      seed = xs(seed);
      bus(1, `PPDM_REG_MEM_OUT, seed);
      pins(32'hffff_ffff, seed);
      bus(1, `PPDM_REG_MEM_IN, 32'h0);
      bus(1, 4'hf, seed);
      bus(0, 4'hf, 32'h0);
      repeat (3) @(posedge clk_i);
      end_sim;
   end
endmodule // ppdm_data_mux_tb
bind ppdm_data_mux ppdm_sva u_ppdm_sva (.clk_i, .resetn_i,
   .boot_select_strap_i, .hold_req_i, .test_resetn_i, .emulation_pin_zero_i,
   .emulation_off_pin_i, .host_cycle_i, .host_write_i, .reg_addr_i,
   .reg_wdata_i, .reg_wr_i, .pad_oe_o, .keep_en_o, .host_word_done_o);
